// *** src/cfr_pkg.sv ***
// package: constants and types for the commanded field rotation block
package cfr_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_RESP = 8'h04;
  localparam logic [7:0] OFF_VALUE = 8'h08;

  // response register field positions
  localparam int RESP_ACK_LSB = 0;
  localparam int RESP_SRC_LSB = 8;
  localparam int RESP_RUN_BIT = 16;

  // command codes
  localparam int CMD_W = 8;
  localparam logic [CMD_W-1:0] CMD_NONE = 8'h00;
  localparam logic [CMD_W-1:0] CMD_REPORT_A = 8'h01;
  localparam logic [CMD_W-1:0] CMD_REPORT_B = 8'h02;
  localparam logic [CMD_W-1:0] CMD_CLEAR = 8'h03;
  localparam logic [CMD_W-1:0] CMD_ADD_NET = 8'h29;
  localparam logic [CMD_W-1:0] CMD_ADD_RATE = 8'h2E;

  // acknowledge count
  localparam int ACK_W = 2;
  localparam logic [ACK_W-1:0] ACK_RESET = 2'h0;
  localparam logic [ACK_W-1:0] ACK_FIRST = 2'h1;
  localparam logic [ACK_W-1:0] ACK_LAST = 2'h3;

  // data-source codes
  localparam int SRC_W = 8;
  localparam logic [SRC_W-1:0] SRC_NONE = 8'h00;
  localparam logic [SRC_W-1:0] SRC_NET = 8'h01;
  localparam logic [SRC_W-1:0] SRC_RATE = 8'h06;
  localparam logic [SRC_W-1:0] SRC_SETUP = 8'h1E;

  // floating-point word
  localparam int FP_W = 32;
  localparam logic [FP_W-1:0] FP_ZERO = 32'h0000_0000;

  // rotation list size
  localparam int ROT_DEPTH = 8;

  // refresh timing
  localparam int CLK_HZ = 20_000_000;
  localparam int REFRESH_MS = 60;
  localparam int MS_PER_S = 1000;
  localparam int REFRESH_CYCLES = (REFRESH_MS * (CLK_HZ / MS_PER_S) > 0) ?
    REFRESH_MS * (CLK_HZ / MS_PER_S) : 1;

  typedef enum logic [0:0] {
    CFR_FLD_NET = 1'b0,
    CFR_FLD_RATE = 1'b1
  } cfr_field_t;

  typedef enum logic [0:0] {
    CFR_ST_SETUP = 1'b0,
    CFR_ST_REPORT = 1'b1
  } cfr_state_t;

endpackage

// *** src/cfr_tick.sv ***
// refresh tick generator: one-cycle pulse every CYCLES clocks
`timescale 1ns/1ps
module cfr_tick #(
  parameter int CYCLES = cfr_pkg::REFRESH_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  output logic tick
);
  localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic tick_q;
  logic tick_d;

  always_comb begin
    tick_d = 1'b0;
    cnt_d = cnt_q + CW'(1);
    if (cnt_q == LAST) begin
      cnt_d = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule

// *** src/cfr_top.sv ***
// commanded field rotation: command decoder with apb register access
//
// Function
// - each add command steps ack 1,2,3 then wraps to 1, clear sets ack 1; all setup commands report source 30, 0.0.
// - code 1 gives ack 1, reports the next field like code 2, first one net.
// - code 2 gives ack 2 and reports the next field, rate.
// - current field is presented every refresh until a new report, add or clear command.
// - an unchanged command word is no new request.
// - value refreshed every 60 ms without moving the rotation pointer.
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module cfr_top #(
  parameter int ROT_DEPTH = cfr_pkg::ROT_DEPTH,
  parameter int REFRESH_CYCLES = cfr_pkg::REFRESH_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [cfr_pkg::FP_W-1:0] net_weight,
  input wire logic [cfr_pkg::FP_W-1:0] rate_value,
  output logic [cfr_pkg::ACK_W-1:0] cmd_ack,
  output logic [cfr_pkg::SRC_W-1:0] src_code,
  output logic [cfr_pkg::FP_W-1:0] fp_value,
  output logic reporting
);
  localparam int PW = $clog2(ROT_DEPTH);
  localparam int NW = PW + 1;
  localparam logic [NW-1:0] FULL = NW'(ROT_DEPTH);
  localparam int AW = cfr_pkg::ACK_W;

  // apb state
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic acc_first;
  logic wr_cmd;

  // command state
  logic [cfr_pkg::CMD_W-1:0] cmd_q;
  logic [cfr_pkg::CMD_W-1:0] cmd_d;
  logic [cfr_pkg::CMD_W-1:0] last_q;
  logic [cfr_pkg::CMD_W-1:0] last_d;
  logic fire;

  // rotation state
  cfr_pkg::cfr_state_t state_q;
  cfr_pkg::cfr_state_t state_d;
  logic [PW-1:0] ptr_q;
  logic [PW-1:0] ptr_d;
  logic [NW-1:0] count_q;
  logic [NW-1:0] count_d;
  cfr_pkg::cfr_field_t rot_q [ROT_DEPTH];
  cfr_pkg::cfr_field_t rot_d [ROT_DEPTH];
  logic app_en;
  cfr_pkg::cfr_field_t app_fld;

  // response state
  logic [cfr_pkg::ACK_W-1:0] ack_q;
  logic [cfr_pkg::ACK_W-1:0] ack_d;
  logic [cfr_pkg::SRC_W-1:0] src_q;
  logic [cfr_pkg::SRC_W-1:0] src_d;
  logic [cfr_pkg::FP_W-1:0] fp_q;
  logic [cfr_pkg::FP_W-1:0] fp_d;
  logic tick;
  logic [cfr_pkg::FP_W-1:0] cur_val;

  cfr_tick #(
    .CYCLES(REFRESH_CYCLES)
  ) u_tick (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .tick(tick)
  );

  // apb slave, one wait state
  always_comb begin
    acc_first = psel && penable && !pready_q;
    wr_cmd = psel && penable && pready_q && pwrite &&
      (paddr == cfr_pkg::OFF_CMD) && !pslverr_q;
    pready_d = acc_first;
    prdata_d = '0;
    pslverr_d = 1'b0;
    if (acc_first) begin
      if (paddr == cfr_pkg::OFF_CMD) begin
        prdata_d = 32'(cmd_q);
      end else if (paddr == cfr_pkg::OFF_RESP) begin
        prdata_d = (32'(ack_q) << cfr_pkg::RESP_ACK_LSB) |
          (32'(src_q) << cfr_pkg::RESP_SRC_LSB) |
          (32'(state_q) << cfr_pkg::RESP_RUN_BIT);
      end else if (paddr == cfr_pkg::OFF_VALUE) begin
        prdata_d = 32'(fp_q);
      end else begin
        pslverr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // command word and change detection
  always_comb begin
    cmd_d = wr_cmd ? pwdata[cfr_pkg::CMD_W-1:0] : cmd_q;
    last_d = cmd_q;
    fire = (cmd_q != last_q);
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_q <= cfr_pkg::CMD_NONE;
      last_q <= cfr_pkg::CMD_NONE;
    end else begin
      cmd_q <= cmd_d;
      last_q <= last_d;
    end
  end

  // command interpreter
  always_comb begin
    state_d = state_q;
    ptr_d = ptr_q;
    count_d = count_q;
    ack_d = ack_q;
    src_d = src_q;
    fp_d = fp_q;
    app_en = 1'b0;
    app_fld = cfr_pkg::CFR_FLD_NET;
    if (fire) begin
      if (cmd_q == cfr_pkg::CMD_CLEAR) begin
        count_d = '0;
        ptr_d = '0;
        state_d = cfr_pkg::CFR_ST_SETUP;
        ack_d = cfr_pkg::ACK_FIRST;
        src_d = cfr_pkg::SRC_SETUP;
        fp_d = cfr_pkg::FP_ZERO;
      end else if (cmd_q == cfr_pkg::CMD_ADD_NET ||
                   cmd_q == cfr_pkg::CMD_ADD_RATE) begin
        app_en = (count_q != FULL);
        app_fld = (cmd_q == cfr_pkg::CMD_ADD_RATE) ?
          cfr_pkg::CFR_FLD_RATE : cfr_pkg::CFR_FLD_NET;
        if (app_en) begin
          count_d = count_q + NW'(1);
        end
        state_d = cfr_pkg::CFR_ST_SETUP;
        ack_d = (ack_q == cfr_pkg::ACK_LAST) ? cfr_pkg::ACK_FIRST :
          ack_q + AW'(1);
        src_d = cfr_pkg::SRC_SETUP;
        fp_d = cfr_pkg::FP_ZERO;
      end else if (cmd_q == cfr_pkg::CMD_REPORT_A ||
                   cmd_q == cfr_pkg::CMD_REPORT_B) begin
        if (state_q == cfr_pkg::CFR_ST_SETUP) begin
          ptr_d = '0;
        end else if (NW'(ptr_q) + NW'(1) >= count_q) begin
          ptr_d = '0;
        end else begin
          ptr_d = ptr_q + PW'(1);
        end
        state_d = cfr_pkg::CFR_ST_REPORT;
        ack_d = cmd_q[AW-1:0];
        if (count_q == '0) begin
          src_d = cfr_pkg::SRC_SETUP;
          fp_d = cfr_pkg::FP_ZERO;
        end else if (rot_q[ptr_d] == cfr_pkg::CFR_FLD_RATE) begin
          src_d = cfr_pkg::SRC_RATE;
          fp_d = rate_value;
        end else begin
          src_d = cfr_pkg::SRC_NET;
          fp_d = net_weight;
        end
      end
    end else if (tick && state_q == cfr_pkg::CFR_ST_REPORT &&
                 count_q != '0) begin
      // refresh current field only, pointer untouched
      if (rot_q[ptr_q] == cfr_pkg::CFR_FLD_RATE) begin
        fp_d = rate_value;
      end else begin
        fp_d = net_weight;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= cfr_pkg::CFR_ST_SETUP;
      ptr_q <= '0;
      count_q <= '0;
      ack_q <= cfr_pkg::ACK_RESET;
      src_q <= cfr_pkg::SRC_NONE;
      fp_q <= cfr_pkg::FP_ZERO;
    end else begin
      state_q <= state_d;
      ptr_q <= ptr_d;
      count_q <= count_d;
      ack_q <= ack_d;
      src_q <= src_d;
      fp_q <= fp_d;
    end
  end

  // rotation list entries
  for (genvar i = 0; i < ROT_DEPTH; i++) begin : g_rot
    always_comb begin
      rot_d[i] = rot_q[i];
      if (app_en && count_q == NW'(i)) begin
        rot_d[i] = app_fld;
      end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        rot_q[i] <= cfr_pkg::CFR_FLD_NET;
      end else begin
        rot_q[i] <= rot_d[i];
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cmd_ack = ack_q;
  assign src_code = src_q;
  assign fp_value = fp_q;
  assign reporting = state_q;

  // current field value, for the refresh check
  assign cur_val = (rot_q[ptr_q] == cfr_pkg::CFR_FLD_RATE) ? rate_value :
    net_weight;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_setup_answer: assert property (
    fire && (cmd_q == cfr_pkg::CMD_ADD_NET ||
      cmd_q == cfr_pkg::CMD_ADD_RATE) |=> src_q == cfr_pkg::SRC_SETUP &&
      fp_q == cfr_pkg::FP_ZERO && state_q == cfr_pkg::CFR_ST_SETUP)
    else $error("setup command answer wrong");

  a_clear_empty: assert property (
    fire && cmd_q == cfr_pkg::CMD_CLEAR |=> count_q == '0 &&
      ptr_q == '0 && ack_q == cfr_pkg::ACK_FIRST)
    else $error("clear did not empty rotation");

  a_ack_step: assert property (
    fire && (cmd_q == cfr_pkg::CMD_ADD_NET ||
      cmd_q == cfr_pkg::CMD_ADD_RATE) && ack_q != cfr_pkg::ACK_LAST |=>
      ack_q == $past(ack_q) + AW'(1))
    else $error("setup acknowledge did not count up");

  a_report_first: assert property (
    fire && cmd_q == cfr_pkg::CMD_REPORT_A &&
      state_q == cfr_pkg::CFR_ST_SETUP && count_q != '0 &&
      rot_q[0] == cfr_pkg::CFR_FLD_NET |=> ack_q == 2'h1 &&
      src_q == cfr_pkg::SRC_NET && fp_q == $past(net_weight))
    else $error("first report not net weight");

  a_report_next: assert property (
    fire && cmd_q == cfr_pkg::CMD_REPORT_B |=> ack_q == 2'h2 &&
      state_q == cfr_pkg::CFR_ST_REPORT)
    else $error("code 2 not acknowledged with 2");

  a_src_matches: assert property (
    state_q == cfr_pkg::CFR_ST_REPORT && count_q != '0 |->
      src_q == ((rot_q[ptr_q] == cfr_pkg::CFR_FLD_RATE) ?
      cfr_pkg::SRC_RATE : cfr_pkg::SRC_NET))
    else $error("source code disagrees with field");

  a_stale_cmd: assert property (
    cmd_q == last_q |=> $stable(ack_q) && $stable(ptr_q) &&
      $stable(src_q))
    else $error("unchanged command acted on");

  a_refresh_value: assert property (
    !fire && tick && state_q == cfr_pkg::CFR_ST_REPORT &&
      count_q != '0 |=> $stable(ptr_q) && fp_q == $past(cur_val))
    else $error("refresh wrong or moved pointer");

  a_hold_value: assert property (
    !fire && !tick |=> $stable(fp_q))
    else $error("value changed without refresh");

  a_apb_wait: assert property (
    psel && penable && !pready_q |=> pready_q ##1 !pready_q)
    else $error("apb ready not one cycle");
endmodule

// *** tb/cfr_plc.sv ***
// controller model: drives the apb command side of the block
`timescale 1ns/1ps
module cfr_plc (
  input wire logic core_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // one transfer, bounded wait for ready
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic err,
    output logic to);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    to = (n >= 20);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  // write a command word, then wait for the response
  task automatic cmd(input logic [7:0] c, output logic to);
    logic [31:0] rd;
    logic err;
    xfer(1'b1, cfr_pkg::OFF_CMD, {24'h00_0000, c}, rd, err, to);
    repeat (2) @(posedge core_clk);
  endtask
endmodule

// *** tb/commanded_field_rotation_test.sv ***
// self-checking bench for the commanded field rotation block
`timescale 1ns/1ps
module commanded_field_rotation_test;
  localparam int RC = 50;
  localparam logic [31:0] NET = 32'h41AE_0000;
  localparam logic [31:0] RATE = 32'h40A0_0000;
  localparam logic [31:0] NEWR = 32'h4120_0000;
  typedef struct {
    logic [7:0] c;
    logic [1:0] ack;
    logic [7:0] src;
    logic [31:0] fp;
    logic rep;
  } cfr_row_t;
  logic core_clk, reset_n, psel, penable, pwrite;
  logic pready, pslverr, reporting;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, net_weight, rate_value, fp_value;
  logic [1:0] cmd_ack;
  logic [7:0] src_code;
  int error_cnt, samples_checked;
  cfr_row_t rows [7];

  cfr_top #(.REFRESH_CYCLES(RC)) u_dut (.core_clk(core_clk),
    .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .net_weight(net_weight), .rate_value(rate_value),
    .cmd_ack(cmd_ack), .src_code(src_code), .fp_value(fp_value),
    .reporting(reporting));

  cfr_plc u_plc (.core_clk(core_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic hang(input logic to);
    if (to) begin
      error_cnt++;
      final_report;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
    input logic eexp);
    logic [31:0] d;
    logic e;
    logic to;
    u_plc.xfer(1'b0, a, 32'h0000_0000, d, e, to);
    hang(to);
    chk(d, exp);
    chk({31'h0, e}, {31'h0, eexp});
  endtask

  task automatic send(input logic [7:0] c);
    logic to;
    u_plc.cmd(c, to);
    hang(to);
  endtask

  function automatic logic [31:0] resp(logic [1:0] a, logic [7:0] s,
    logic r);
    return {15'h0000, r, s, 6'h00, a};
  endfunction

  initial begin
    error_cnt = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    net_weight = NET;
    rate_value = RATE;
    rows[0] = '{8'h03, 2'h1, 8'h1E, 32'h0, 1'b0};
    rows[1] = '{8'h29, 2'h2, 8'h1E, 32'h0, 1'b0};
    rows[2] = '{8'h2E, 2'h3, 8'h1E, 32'h0, 1'b0};
    rows[3] = '{8'h01, 2'h1, 8'h01, NET, 1'b1};
    rows[4] = '{8'h02, 2'h2, 8'h06, RATE, 1'b1};
    rows[5] = '{8'h01, 2'h1, 8'h01, NET, 1'b1};
    rows[6] = '{8'h02, 2'h2, 8'h06, RATE, 1'b1};
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    chk({22'h0, cmd_ack, src_code}, 32'h0);
    chk({31'h0, reporting}, 32'h0);
    chk(fp_value, 32'h0);
    rd(cfr_pkg::OFF_RESP, 32'h0, 1'b0);
    $display("reset test done");
    for (int i = 0; i < 7; i++) begin
      send(rows[i].c);
      chk({21'h0, reporting, cmd_ack, src_code},
        {21'h0, rows[i].rep, rows[i].ack, rows[i].src});
      chk(fp_value, rows[i].fp);
      rd(cfr_pkg::OFF_RESP, resp(rows[i].ack, rows[i].src, rows[i].rep),
        1'b0);
    end
    $display("rotation table done");
    send(8'h02);
    chk({cmd_ack, src_code}, {2'h2, 8'h06});
    $display("repeat command test done");
    net_weight <= NET ^ 32'h0000_0001;
    rate_value <= NEWR;
    repeat (RC + 5) @(posedge core_clk);
    chk(fp_value, NEWR);
    chk(fp_value, (src_code == 8'h06) ? NEWR : NET ^ 32'h1);
    chk({cmd_ack, src_code}, {2'h2, 8'h06});
    rd(cfr_pkg::OFF_VALUE, NEWR, 1'b0);
    $display("refresh test done");
    rd(8'h0C, 32'h0, 1'b1);
    $display("unmapped address test done");
    reset_n <= 1'b0;
    @(posedge core_clk);
    chk({22'h0, cmd_ack, src_code}, 32'h0);
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    chk(fp_value, 32'h0);
    send(8'h01);
    chk({21'h0, reporting, cmd_ack, src_code},
      {21'h0, 1'b1, 2'h1, 8'h1E});
    chk(fp_value, 32'h0);
    $display("mid-run reset test done");
    final_report;
  end
endmodule
